// ===== rtl/opl_map.vh
`ifndef OPL_MAP_VH
`define OPL_MAP_VH
// Register select codes (index of the setting register)
`define OPL_SEL_CONV1      2'h0
`define OPL_SEL_UNUSED     2'h1
`define OPL_SEL_CONV2      2'h2
`define OPL_SEL_NOUSE      2'h3
// Frame layout
`define OPL_DEV_ADDR       8'h4E
`define OPL_FLAG_BIT       7
`define OPL_SEL_HI         6
`define OPL_SEL_LO         5
`define OPL_CODE_W         5
`define OPL_FRAME_BITS     5'h10
`define OPL_BYTE_BITS      5'h08
// Reset values
`define OPL_CODE_RST       5'h00
// Timing, microseconds; clock frequency in MHz
`define OPL_STARTUP_US     170
`define OPL_TIMEOUT_US     520
`define OPL_ACK_US         520
`define OPL_ACKVAL_US      10
`define OPL_CLK_MHZ        20
`endif

// ===== rtl/opl_bit_timer.v
`timescale 1ns/1ps
`include "opl_map.vh"
// Measures low and high time of one bit between falling edges
module opl_bit_timer #(
    parameter CW = 16
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // Control
    input  wire          run,
    input  wire          lineSync,
    input  wire          fallEdge,
    // Result
    output reg           bitValid,
    output reg           bitValue,
    output reg           bitBad,
    output reg  [CW-1:0] lowCount
);
    reg [CW-1:0] lowCnt_r;   // Low time of running bit
    reg [CW-1:0] highCnt_r;  // High time of running bit
    reg          active_r;   // A bit is being measured
    wire [CW-1:0] allOnes = {CW{1'b1}};

    ////////////////////////////////////////////////////////////////////////
    // Counting, saturates so a long level never wraps into a valid ratio
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt_r  <= {CW{1'b0}};
            highCnt_r <= {CW{1'b0}};
            active_r  <= 1'b0;
            bitValid  <= 1'b0;
            bitValue  <= 1'b0;
            bitBad    <= 1'b0;
            lowCount  <= {CW{1'b0}};
        end else begin
            bitValid <= 1'b0;
            bitBad   <= 1'b0;
            lowCount <= lowCnt_r;
            if (!run) begin
                active_r  <= 1'b0;
                lowCnt_r  <= {CW{1'b0}};
                highCnt_r <= {CW{1'b0}};
            end else if (fallEdge) begin
                // Bit spans falling edge to falling edge
                if (active_r) begin
                    // Ratio of at least two decides the bit
                    if ({1'b0, highCnt_r} >= {lowCnt_r, 1'b0}) begin
                        bitValid <= 1'b1;
                        bitValue <= 1'b1;
                    end else if ({1'b0, lowCnt_r} >= {highCnt_r, 1'b0}) begin
                        bitValid <= 1'b1;
                        bitValue <= 1'b0;
                    end else begin
                        bitBad <= 1'b1;
                    end
                end
                active_r  <= 1'b1;
                lowCnt_r  <= {CW{1'b0}};
                highCnt_r <= {CW{1'b0}};
            end else if (active_r) begin
                if (!lineSync && lowCnt_r != allOnes)
                    lowCnt_r <= lowCnt_r + 1'b1;
                else if (lineSync && highCnt_r != allOnes)
                    highCnt_r <= highCnt_r + 1'b1;
            end
        end
    end
endmodule

// ===== rtl/opl_link.v
`timescale 1ns/1ps
`include "opl_map.vh"
module opl_link #(
    parameter STARTUP_CYC = ((`OPL_STARTUP_US * `OPL_CLK_MHZ) + 0),
    parameter TIMEOUT_CYC = (`OPL_TIMEOUT_US * `OPL_CLK_MHZ),
    parameter ACK_CYC     = (`OPL_ACK_US * `OPL_CLK_MHZ),
    parameter ACKVAL_CYC  = (`OPL_ACKVAL_US * `OPL_CLK_MHZ),
    parameter CW          = 16
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Converter enables
    input  wire       conv1_on,
    input  wire       conv2_on,
    // Shared mode/data pin
    input  wire       lineIn,
    output wire       lineOut,
    output wire       lineOe,
    // Mode and settings
    output reg        forcedPwm,
    output reg  [4:0] conv1Setting,
    output reg  [4:0] conv2Setting,
    output wire       ready
);
    localparam ST_OFF   = 3'h0;  // Receiver off
    localparam ST_START = 3'h1;  // Startup wait
    localparam ST_IDLE  = 3'h2;  // Waiting for frame
    localparam ST_RECV  = 3'h3;  // Shifting bits
    localparam ST_VAL   = 3'h4;  // Validation delay
    localparam ST_ACK   = 3'h5;  // Pulling line low

    reg  [2:0]    state_r;       // Receiver state
    reg  [2:0]    state_nxt;
    reg           sync1_r;       // Pin synchroniser, first stage
    reg           sync2_r;       // Pin synchroniser, second stage
    reg           lineDly_r;     // Previous synced level
    reg  [CW-1:0] timer_r;       // Shared wait counter
    reg  [CW-1:0] lowRun_r;      // Continuous low length
    reg  [4:0]    bitCnt_r;      // Bits received in frame
    reg  [15:0]   shift_r;       // Frame shift register
    reg           frameBad_r;    // Malformed bit seen
    reg           ackDrive_r;    // Pull-down switch on
    reg           enSync1_r;     // Enable synchroniser stages
    reg           enSync2_r;

    wire          fallEdge = lineDly_r & ~sync2_r;
    wire          enabled  = enSync2_r;
    wire          bitValid;
    wire          bitValue;
    wire          bitBad;
    wire          timedOut = (lowRun_r >= TIMEOUT_CYC[CW-1:0]);
    // Bit timer idles after a timeout, so the next frame's first edge
    // starts a fresh bit instead of closing the abandoned one
    wire          rxRun    = ((state_r == ST_IDLE) || (state_r == ST_RECV)) && !timedOut;
    wire          frameOk  = (shift_r[15:8] == `OPL_DEV_ADDR) && !frameBad_r;

    assign ready   = (state_r != ST_OFF) && (state_r != ST_START);
    // Open drain: only ever pulls low
    assign lineOut = 1'b0;
    assign lineOe  = ackDrive_r;

    ////////////////////////////////////////////////////////////////////////
    // Bit decoder
    opl_bit_timer #(
        .CW(CW)
    ) u_bit (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (rxRun),
        .lineSync (sync2_r),
        .fallEdge (fallEdge),
        .bitValid (bitValid),
        .bitValue (bitValue),
        .bitBad   (bitBad),
        .lowCount ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers; the pin and enables come from outside the clock domain
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r   <= 1'b1;
            sync2_r   <= 1'b1;
            lineDly_r <= 1'b1;
            enSync1_r <= 1'b0;
            enSync2_r <= 1'b0;
        end else begin
            sync1_r   <= lineIn;
            sync2_r   <= sync1_r;
            lineDly_r <= sync2_r;
            enSync1_r <= conv1_on | conv2_on;
            enSync2_r <= enSync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF:   if (enabled) state_nxt = ST_START;
            ST_START: if (timer_r >= STARTUP_CYC[CW-1:0]) state_nxt = ST_IDLE;
            ST_IDLE:  if (fallEdge) state_nxt = ST_RECV;
            ST_RECV: begin
                if (timedOut)
                    state_nxt = ST_IDLE;
                else if (bitCnt_r == `OPL_FRAME_BITS)
                    state_nxt = ST_VAL;
            end
            ST_VAL: begin
                if (timer_r >= ACKVAL_CYC[CW-1:0])
                    state_nxt = (frameOk && shift_r[`OPL_FLAG_BIT]) ? ST_ACK : ST_IDLE;
            end
            ST_ACK: begin
                // Entry cycle counts too, so the pulse never exceeds its limit
                if ((timer_r + 1'b1) >= ACK_CYC[CW-1:0])
                    state_nxt = ST_IDLE;
            end
            default:  state_nxt = ST_OFF;
        endcase
        if (!enabled)
            state_nxt = ST_OFF;
    end

    ////////////////////////////////////////////////////////////////////////
    // State, counters and frame capture
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_OFF;
            timer_r    <= {CW{1'b0}};
            bitCnt_r   <= 5'h00;
            shift_r    <= 16'h0000;
            frameBad_r <= 1'b0;
            ackDrive_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r)
                timer_r <= {CW{1'b0}};
            else if (timer_r != {CW{1'b1}})
                timer_r <= timer_r + 1'b1;
            ackDrive_r <= (state_nxt == ST_ACK);
            if (state_r == ST_IDLE) begin
                bitCnt_r   <= 5'h00;
                frameBad_r <= 1'b0;
            end else if (state_r == ST_RECV) begin
                if (bitValid) begin
                    // Shift in MSB first
                    shift_r  <= {shift_r[14:0], bitValue};
                    bitCnt_r <= bitCnt_r + 5'h01;
                end else if (bitBad) begin
                    frameBad_r <= 1'b1;
                    bitCnt_r   <= bitCnt_r + 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Low run length for the power-save timeout
    // Counts the synced level, so the limit carries two cycles of sync delay
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowRun_r <= {CW{1'b0}};
        end else if (sync2_r || !enabled) begin
            lowRun_r <= {CW{1'b0}};
        end else if (!timedOut) begin
            lowRun_r <= lowRun_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode: high forces fixed frequency, held until the low timeout
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            forcedPwm <= 1'b0;
        end else if (sync2_r) begin
            forcedPwm <= 1'b1;
        end else if (timedOut) begin
            forcedPwm <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Setting registers, written only from a good frame at end of validation
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv1Setting <= `OPL_CODE_RST;
            conv2Setting <= `OPL_CODE_RST;
        end else if (state_r == ST_VAL && state_nxt != ST_VAL && frameOk) begin
            case (shift_r[`OPL_SEL_HI:`OPL_SEL_LO])
                `OPL_SEL_CONV1: conv1Setting <= shift_r[`OPL_CODE_W-1:0];
                `OPL_SEL_CONV2: conv2Setting <= shift_r[`OPL_CODE_W-1:0];
                default: ;
            endcase
        end
    end
endmodule

// ===== dv/opl_link_props.sv
`timescale 1ns/1ps
// Port-level checks for the one-pin setting link
module opl_link_props #(
    parameter STARTUP_CYC = 3400,
    parameter TIMEOUT_CYC = 10400,
    parameter ACK_CYC     = 10400
) (
    // Clock and reset
    input wire       clk,
    input wire       rst_n,
    // Enables and pin
    input wire       conv1_on,
    input wire       conv2_on,
    input wire       lineIn,
    input wire       lineOut,
    input wire       lineOe,
    // Mode and settings
    input wire       forcedPwm,
    input wire [4:0] conv1Setting,
    input wire [4:0] conv2Setting,
    input wire       ready
);
    reg [15:0] lowCnt_r; // Pin low run
    reg [15:0] oeCnt_r;  // Ack pull run
    reg [15:0] enCnt_r;  // Cycles enabled
    ////////////////////////////////////////
    // Run counters; 16 bits also hold the default counts of up to 10400
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt_r <= 16'h0000;
            oeCnt_r  <= 16'h0000;
            enCnt_r  <= 16'h0000;
        end else begin
            lowCnt_r <= lineIn ? 16'h0000 : lowCnt_r + 16'h0001;
            oeCnt_r  <= lineOe ? oeCnt_r + 16'h0001 : 16'h0000;
            enCnt_r  <= (conv1_on || conv2_on) ? enCnt_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pin_never_high: assert property (lineOut == 1'h0)
        else $error("pin data driven high");
    a_pwm_on_high: assert property ((lineIn && ready) [*5] |-> forcedPwm)
        else $error("high pin without forced mode");
    a_ack_pulse_len: assert property (lineOe |-> oeCnt_r < ACK_CYC)
        else $error("ack pulse too long");
    a_ack_after_low: assert property ($rose(lineOe) |-> $past(lineIn, 8) == 1'h0)
        else $error("ack without validation low");
    a_no_ack_off: assert property (!ready [*2] |-> !lineOe)
        else $error("ack while inactive");
    a_set_in_frame: assert property (!$stable({conv1Setting, conv2Setting}) |-> ready && !lineIn)
        else $error("setting changed outside frame");
    a_pwm_kept_frame: assert property ($fell(forcedPwm) && ready |-> lowCnt_r >= TIMEOUT_CYC)
        else $error("forced mode left early");
    a_save_timeout: assert property (ready && lowCnt_r == TIMEOUT_CYC + 8 |-> !forcedPwm)
        else $error("power save late");
    a_ready_startup: assert property ($rose(ready) |-> enCnt_r >= STARTUP_CYC)
        else $error("ready before startup");
    c_ack: cover property ($rose(lineOe));
    c_save: cover property ($fell(forcedPwm));
    c_set2: cover property (!$stable(conv2Setting));
endmodule

// ===== dv/opl_host.sv
`timescale 1ns/1ps
// Host model: open-drain driver with pull-up on the pin
module opl_host (
    // Clock
    input  wire clk,
    // Pin
    input  wire lineOe,
    output wire lineIn
);
    reg hostLow = 1'h0; // Host pull-down on
    // Wired pin, pull-up idles it high; open drain allows ack
    assign lineIn = !(hostLow || lineOe);
    // Hold a level n cycles; entered just after an edge
    task drive(input lo, input integer n);
        begin
            hostLow = lo;
            repeat (n) @(posedge clk);
            #2;
        end
    endtask
    // Send 16 bits; bit bad gets an even ratio
    task send(input [15:0] w, input integer bad, output ack);
        integer i;
        begin
            drive(1'h0, 10);
            for (i = 15; i >= 0; i = i - 1) begin
                if (i == bad) begin
                    drive(1'h1, 8);
                    drive(1'h0, 8);
                end else if (w[i]) begin
                    drive(1'h1, 4);
                    drive(1'h0, 12);
                end else begin
                    drive(1'h1, 12);
                    drive(1'h0, 4);
                end
            end
            drive(1'h1, 20);
            drive(1'h0, 2);
            ack = !lineIn;
            for (i = 0; i < 300 && lineOe; i = i + 1)
                drive(1'h0, 1);
            drive(1'h0, 10);
        end
    endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
// Bench for the one-pin setting link
module tb_top;
    localparam ST = 40;  // Short startup
    localparam TO = 400; // Short timeout
    reg        clk      = 1'h0;
    reg        rst_n    = 1'h0;
    reg        conv1_on = 1'h0;
    reg        conv2_on = 1'h0;
    wire       lineIn;
    wire       lineOut;
    wire       lineOe;
    wire       forcedPwm;
    wire       ready;
    wire [4:0] conv1Setting;
    wire [4:0] conv2Setting;
    integer    n_errors = 0;
    integer    compares = 0;
    always #25 clk = ~clk;
    opl_link #(.STARTUP_CYC(ST), .TIMEOUT_CYC(TO), .ACK_CYC(100), .ACKVAL_CYC(10)) u_opl_link (
        .clk(clk), .rst_n(rst_n), .conv1_on(conv1_on), .conv2_on(conv2_on), .lineIn(lineIn),
        .lineOut(lineOut), .lineOe(lineOe), .forcedPwm(forcedPwm), .conv1Setting(conv1Setting),
        .conv2Setting(conv2Setting), .ready(ready));
    opl_host u_opl_host (.clk(clk), .lineOe(lineOe), .lineIn(lineIn));
    ////////////////////////////////////////
    task summarize;
        begin
            $display("errors %0d compares %0d", n_errors, compares);
            if (n_errors == 0 && compares > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chkBit(input got, input exp, input [8*16-1:0] m);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: %0s", $time, m);
            end
        end
    endtask
    task chkSet(input [4:0] got, input [4:0] exp, input [8*16-1:0] m);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: %0s", $time, m);
            end
        end
    endtask
    // One frame, then ack and both settings judged
    task frame(input [15:0] w, input integer bad, input ea, input [4:0] e1, input [4:0] e2);
        reg ack;
        begin
            u_opl_host.send(w, bad, ack);
            chkBit(ack, ea, "ack");
            chkBit(lineOe, 1'h0, "ack stuck");
            if (lineOe !== 1'h0)
                summarize;
            chkSet(conv1Setting, e1, "conv1");
            chkSet(conv2Setting, e2, "conv2");
        end
    endtask
    task t_startup;
        integer i;
        begin
            chkBit(ready, 1'h0, "ready idle");
            chkSet(conv1Setting, 5'h00, "reset set");
            conv1_on = 1'h1;
            for (i = 0; i < 200 && ready !== 1'h1; i = i + 1) begin
                @(posedge clk);
                #2;
            end
            chkBit(i >= ST, 1'h1, "early ready");
            chkBit(ready, 1'h1, "no ready");
            if (ready !== 1'h1)
                summarize;
        end
    endtask
    task t_writes;
        begin
            frame({8'h4E, 3'h4, 5'h15}, 16, 1'h1, 5'h15, 5'h00);
            frame({8'h4E, 3'h2, 5'h0A}, 16, 1'h0, 5'h15, 5'h0A);
            frame({8'h4E, 3'h6, 5'h1F}, 16, 1'h1, 5'h15, 5'h1F);
        end
    endtask
    // Reversed address, unused selects, a broken bit
    task t_refused;
        begin
            frame({8'h72, 3'h4, 5'h01}, 16, 1'h0, 5'h15, 5'h1F);
            frame({8'h4E, 3'h1, 5'h02}, 16, 1'h0, 5'h15, 5'h1F);
            frame({8'h4E, 3'h3, 5'h03}, 16, 1'h0, 5'h15, 5'h1F);
            frame({8'h4E, 3'h5, 5'h05}, 16, 1'h1, 5'h15, 5'h1F);
            frame({8'h4E, 3'h7, 5'h06}, 16, 1'h1, 5'h15, 5'h1F);
            frame({8'h4E, 3'h4, 5'h04}, 3, 1'h0, 5'h15, 5'h1F);
        end
    endtask
    task t_mode;
        begin
            chkBit(forcedPwm, 1'h1, "pwm idle");
            u_opl_host.drive(1'h1, TO + 20);
            chkBit(forcedPwm, 1'h0, "no save");
            u_opl_host.drive(1'h0, 5);
            chkBit(forcedPwm, 1'h1, "pwm late");
            frame({8'h4E, 3'h0, 5'h0C}, 16, 1'h0, 5'h0C, 5'h1F);
        end
    endtask
    task t_disable;
        begin
            conv2_on = 1'h1;
            conv1_on = 1'h0;
            repeat (5) @(posedge clk);
            #2;
            chkBit(ready, 1'h1, "ready conv2");
            conv2_on = 1'h0;
            repeat (5) @(posedge clk);
            #2;
            chkBit(ready, 1'h0, "ready off");
            frame({8'h4E, 3'h4, 5'h07}, 16, 1'h0, 5'h0C, 5'h1F);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #2;
        rst_n = 1'h1;
        t_startup;
        t_writes;
        t_refused;
        t_mode;
        t_disable;
        summarize;
    end
endmodule
bind opl_link opl_link_props #(.STARTUP_CYC(STARTUP_CYC), .TIMEOUT_CYC(TIMEOUT_CYC), .ACK_CYC(ACK_CYC))
    u_opl_link_props (.clk(clk), .rst_n(rst_n), .conv1_on(conv1_on), .conv2_on(conv2_on),
    .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe), .forcedPwm(forcedPwm),
    .conv1Setting(conv1Setting), .conv2Setting(conv2Setting), .ready(ready));
